// >>> bkc_pkg.sv
package bkc_pkg;
  localparam int CLK_MHZ         = 50;
  localparam int SS_SLOW_US      = 600;
  localparam int SS_FAST_US      = 250;
  localparam int SS_LSLOW_US     = 450;
  localparam int SS_LFAST_US     = 188;
  localparam int RESTART_MS      = 14;
  localparam int SYS_RESTART_MS  = 100;
  localparam int SLEW_STEP_NS    = 1000;
  localparam int SS_SLOW_CYC     = SS_SLOW_US * CLK_MHZ;
  localparam int SS_FAST_CYC     = SS_FAST_US * CLK_MHZ;
  localparam int SS_LSLOW_CYC    = SS_LSLOW_US * CLK_MHZ;
  localparam int SS_LFAST_CYC    = SS_LFAST_US * CLK_MHZ;
  localparam int RESTART_CYC     = RESTART_MS * 1000 * CLK_MHZ;
  localparam int SYS_RESTART_CYC = SYS_RESTART_MS * 1000 * CLK_MHZ;
  localparam int SLEW_CYC        = SLEW_STEP_NS * CLK_MHZ / 1000;
  localparam int OCP_CYCLES      = 16;
  localparam int CNT_W           = 23;
  localparam int LOW_BASE_UV     = 600000;
  localparam int LOW_STEP_UV     = 9376;
  localparam int HIGH_BASE_UV    = 800000;
  localparam int HIGH_STEP_UV    = 12500;
  localparam logic [7:0] ADDR_GLB = 8'h00;
  localparam logic [7:0] ADDR_SYS = 8'h01;
  localparam logic [4:0] BANK0    = 5'h02;
  localparam logic [2:0] OFS_PRI  = 3'h0;
  localparam logic [2:0] OFS_SEC  = 3'h1;
  localparam logic [2:0] OFS_CTL  = 3'h2;
  localparam logic [2:0] OFS_ILIM = 3'h3;
  localparam logic [2:0] OFS_STAT = 3'h4;
  localparam int GLB_LLD = 0;
  localparam int GLB_LPS = 1;
  localparam int GLB_FAST = 2;
  localparam int GLB_DVS = 3;
  localparam int CTL_ON = 0;
  localparam int CTL_REF = 1;
  localparam int CTL_PDLY = 2;
  localparam int CTL_PFALL = 3;
  localparam int CTL_FSW = 4;
  localparam int CTL_VMASK = 5;
  localparam int CTL_CMASK = 6;
  localparam logic [7:0] GLB_RST  = 8'h00;
  localparam logic [7:0] PRI_RST  = 8'h80;
  localparam logic [7:0] SEC_RST  = 8'h60;
  localparam logic [7:0] CTL_RST  = 8'h01;
  localparam logic [3:0] ILIM_RST = 4'h8;
  typedef enum {CH_OFF, CH_RAMP, CH_RUN, CH_WAIT} bkc_ch_t;
  typedef enum {SYS_RUN, SYS_FAULT} bkc_sys_t;
endpackage

// >>> bkc_ocp.sv
`timescale 1ns/1ps
module bkc_ocp #(
  parameter int RUN_LEN = bkc_pkg::OCP_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic hit,
  input  wire logic clear,
  output logic      flag
);
  localparam int CW = $clog2(RUN_LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(RUN_LEN - 1);

  if (RUN_LEN < 1) begin : g_chk
    $error("bkc_ocp: RUN_LEN must be at least 1");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          flag_q;
  logic          flag_d;

  // The count saturates so that every further hit cycle keeps the flag set,
  // and a new detection beats a clearing read in the same cycle.
  always_comb begin
    cnt_d  = cnt_q;
    flag_d = flag_q & ~clear;
    if (tick) begin
      if (hit) begin
        if (cnt_q == LAST) begin
          flag_d = 1'b1;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end else begin
        cnt_d = '0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q  <= '0;
      flag_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;
endmodule

// >>> bkc_top.sv
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module bkc_top #(
  parameter int       SS_SLOW_CYC     = bkc_pkg::SS_SLOW_CYC,
  parameter int       SS_FAST_CYC     = bkc_pkg::SS_FAST_CYC,
  parameter int       SS_LSLOW_CYC    = bkc_pkg::SS_LSLOW_CYC,
  parameter int       SS_LFAST_CYC    = bkc_pkg::SS_LFAST_CYC,
  parameter int       RESTART_CYC     = bkc_pkg::RESTART_CYC,
  parameter int       SYS_RESTART_CYC = bkc_pkg::SYS_RESTART_CYC,
  parameter int       SLEW_CYC        = bkc_pkg::SLEW_CYC,
  parameter logic [2:0] FOLLOW_MASK   = 3'h0,
  parameter logic     REG1_LOW_REF    = 1'b0
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  input  wire logic              dvs_pin,
  input  wire logic [2:0]        sw_tick,
  input  wire logic [2:0]        warn_cmp,
  input  wire logic [2:0]        lim_cmp,
  input  wire logic [2:0]        short_cmp,
  input  wire logic [2:0]        uv_cmp,
  input  wire logic [2:0]        ov_cmp,
  input  wire logic [2:0]        duty_full,
  output logic [2:0]             reg_enable,
  output logic [2:0]             discharge_en,
  output logic [2:0]             ramp_busy,
  output logic [2:0]             hs_hold,
  output logic [2:0]             hs_cut,
  output logic [2:0]             fixed_frequency_force,
  output logic [2:0][21:0]       target_uv,
  output logic [2:0][3:0]        peak_limit_setting,
  output logic [2:0]             phase_delay_en,
  output logic [2:0]             phase_fall_edge,
  output logic [2:0]             fsw_half,
  output logic                   extra_light_load_mode,
  output logic                   voltage_fault_state,
  output logic                   interrupt_out_n
);
  localparam int CW = bkc_pkg::CNT_W;
  localparam int MAXC = 2 ** CW - 1;

  if (SS_SLOW_CYC < 1 || SS_SLOW_CYC > MAXC || SS_FAST_CYC < 1 || SS_FAST_CYC > MAXC ||
      SS_LSLOW_CYC < 1 || SS_LSLOW_CYC > MAXC || SS_LFAST_CYC < 1 || SS_LFAST_CYC > MAXC ||
      RESTART_CYC < 1 || RESTART_CYC > MAXC || SYS_RESTART_CYC < 1 ||
      SYS_RESTART_CYC > MAXC || SLEW_CYC < 1 || SLEW_CYC > 255) begin : g_chk
    $error("bkc_top: a cycle count is out of range");
  end

  function automatic logic [2:0] bank_hit(input logic [7:0] a);
    logic [2:0] h;
    for (int c = 0; c < 3; c++) begin
      h[c] = (a[7:3] == bkc_pkg::BANK0 + 5'(c));
    end
    return h;
  endfunction

  function automatic logic [21:0] decode_uv(input logic [7:0] code, input logic low);
    int uv;
    if (low) begin
      uv = bkc_pkg::LOW_BASE_UV + int'(code) * bkc_pkg::LOW_STEP_UV;
    end else begin
      uv = bkc_pkg::HIGH_BASE_UV + int'(code) * bkc_pkg::HIGH_STEP_UV;
    end
    return uv[21:0];
  endfunction

  // Two-stage synchronisers for every pin coming from the analog side.
  logic [21:0] pin_raw;
  logic [21:0] meta_q;
  logic [21:0] sync_q;
  logic [2:0]  tick_prev_q;
  assign pin_raw = {dvs_pin, duty_full, ov_cmp, uv_cmp, short_cmp, lim_cmp, warn_cmp, sw_tick};
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q      <= '0;
      sync_q      <= '0;
      tick_prev_q <= '0;
    end else begin
      meta_q      <= pin_raw;
      sync_q      <= meta_q;
      tick_prev_q <= sync_q[2:0];
    end
  end

  logic [2:0] tick_s;
  logic [2:0] warn_s;
  logic [2:0] lim_s;
  logic [2:0] short_s;
  logic [2:0] uv_s;
  logic [2:0] ov_s;
  logic [2:0] duty_s;
  logic       dvs_s;
  assign tick_s  = sync_q[2:0] & ~tick_prev_q;
  assign warn_s  = sync_q[5:3];
  assign lim_s   = sync_q[8:6];
  assign short_s = sync_q[11:9];
  assign uv_s    = sync_q[14:12];
  assign ov_s    = sync_q[17:15];
  assign duty_s  = sync_q[20:18];
  assign dvs_s   = sync_q[21];

  // Configuration registers written by the host.
  logic [7:0]       glb_q;
  logic [7:0]       glb_d;
  logic [2:0][7:0]  pri_q;
  logic [2:0][7:0]  pri_d;
  logic [2:0][7:0]  sec_q;
  logic [2:0][7:0]  sec_d;
  logic [2:0][7:0]  ctl_q;
  logic [2:0][7:0]  ctl_d;
  logic [2:0][3:0]  ilim_q;
  logic [2:0][3:0]  ilim_d;
  logic [2:0]       wr_bank;
  assign wr_bank = reg_wr ? bank_hit(reg_addr) : 3'h0;

  always_comb begin
    glb_d  = glb_q;
    pri_d  = pri_q;
    sec_d  = sec_q;
    ctl_d  = ctl_q;
    ilim_d = ilim_q;
    if (reg_wr && reg_addr == bkc_pkg::ADDR_GLB) begin
      glb_d = {4'h0, reg_wdata[3:0]};
    end
    for (int c = 0; c < 3; c++) begin
      if (wr_bank[c]) begin
        case (reg_addr[2:0])
          bkc_pkg::OFS_PRI:  pri_d[c] = reg_wdata;
          bkc_pkg::OFS_SEC:  sec_d[c] = reg_wdata;
          bkc_pkg::OFS_CTL: begin
            ctl_d[c] = {1'b0, reg_wdata[6:0]};
            // Only the second regulator's reference select is writable.
            if (c != 1) begin
              ctl_d[c][bkc_pkg::CTL_REF] = 1'b0;
            end
          end
          bkc_pkg::OFS_ILIM: ilim_d[c] = reg_wdata[3:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      glb_q  <= bkc_pkg::GLB_RST;
      pri_q  <= {3{bkc_pkg::PRI_RST}};
      sec_q  <= {3{bkc_pkg::SEC_RST}};
      ctl_q  <= {3{bkc_pkg::CTL_RST}};
      ilim_q <= {3{bkc_pkg::ILIM_RST}};
    end else begin
      glb_q  <= glb_d;
      pri_q  <= pri_d;
      sec_q  <= sec_d;
      ctl_q  <= ctl_d;
      ilim_q <= ilim_d;
    end
  end

  // Reference choice per regulator: low means the 0.6V reference.
  logic [2:0] low_ref;
  assign low_ref[0] = REG1_LOW_REF;
  assign low_ref[1] = ~ctl_q[1][bkc_pkg::CTL_REF];
  assign low_ref[2] = 1'b0;

  logic       dvs_sel;
  logic [2:0] clr;
  logic [2:0] en_eff;
  assign dvs_sel = glb_q[bkc_pkg::GLB_DVS] | dvs_s;
  assign clr     = reg_rd ? (bank_hit(reg_addr) & {3{reg_addr[2:0] == bkc_pkg::OFS_STAT}}) : 3'h0;
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      // Dependents of the first regulator follow it when the factory image says so.
      en_eff[c] = ctl_q[c][bkc_pkg::CTL_ON] &
                  (~FOLLOW_MASK[c] | ctl_q[0][bkc_pkg::CTL_ON]);
    end
  end

  // Cycle-by-cycle current monitoring, one pair of counters per regulator.
  logic [2:0] warn_f;
  logic [2:0] lim_f;
  for (genvar g = 0; g < 3; g++) begin : g_ocp
    bkc_ocp #(.RUN_LEN(bkc_pkg::OCP_CYCLES)) u_warn (
      .core_clk (core_clk),
      .rst      (rst),
      .tick     (tick_s[g]),
      .hit      (warn_s[g]),
      .clear    (clr[g]),
      .flag     (warn_f[g])
    );
    bkc_ocp #(.RUN_LEN(bkc_pkg::OCP_CYCLES)) u_lim (
      .core_clk (core_clk),
      .rst      (rst),
      .tick     (tick_s[g]),
      .hit      (lim_s[g]),
      .clear    (clr[g]),
      .flag     (lim_f[g])
    );
  end

  // Whole-device fault state after a short on any ramping or running regulator.
  bkc_pkg::bkc_sys_t sys_q;
  bkc_pkg::bkc_sys_t sys_d;
  logic [CW-1:0]     sys_cnt_q;
  logic [CW-1:0]     sys_cnt_d;
  logic [2:0]        short_ev;

  always_comb begin
    sys_d     = sys_q;
    sys_cnt_d = sys_cnt_q;
    case (sys_q)
      bkc_pkg::SYS_RUN: begin
        if (|short_ev) begin
          sys_d     = bkc_pkg::SYS_FAULT;
          sys_cnt_d = CW'(SYS_RESTART_CYC - 1);
        end
      end
      bkc_pkg::SYS_FAULT: begin
        if (sys_cnt_q == '0) begin
          sys_d = bkc_pkg::SYS_RUN;
        end else begin
          sys_cnt_d = sys_cnt_q - CW'(1);
        end
      end
      default: sys_d = bkc_pkg::SYS_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sys_q     <= bkc_pkg::SYS_RUN;
      sys_cnt_q <= '0;
    end else begin
      sys_q     <= sys_d;
      sys_cnt_q <= sys_cnt_d;
    end
  end

  // Per-regulator sequencing, setpoint slewing and voltage fault flags.
  bkc_pkg::bkc_ch_t st_q [3];
  bkc_pkg::bkc_ch_t st_d [3];
  logic [CW-1:0]    cnt_q [3];
  logic [CW-1:0]    cnt_d [3];
  logic [2:0][7:0]  code_q;
  logic [2:0][7:0]  code_d;
  logic [7:0]       slew_q;
  logic [7:0]       slew_d;
  logic [2:0]       ovf_q, ovf_d, uvf_q, uvf_d, shf_q, shf_d;
  logic [2:0]       vint_q, vint_d, seen_q, seen_d;
  logic [2:0]       pg_q, pg_d, force_q, force_d;
  logic [2:0]       on_d, hold_d, cut_d;
  logic [2:0][21:0] tuv_d;

  always_comb begin
    logic [7:0]    tgt;
    logic [CW-1:0] ramp;
    logic          stop;
    logic          slew_tick;
    tgt       = '0;
    ramp      = '0;
    stop      = 1'b0;
    slew_tick = (slew_q == '0);
    slew_d    = slew_tick ? 8'(SLEW_CYC - 1) : slew_q - 8'h01;
    for (int c = 0; c < 3; c++) begin
      st_d[c]   = st_q[c];
      cnt_d[c]  = cnt_q[c];
      code_d[c] = code_q[c];
      tgt       = dvs_sel ? sec_q[c] : pri_q[c];
      if (glb_q[bkc_pkg::GLB_FAST]) begin
        ramp = low_ref[c] ? CW'(SS_LFAST_CYC - 1) : CW'(SS_FAST_CYC - 1);
      end else begin
        ramp = low_ref[c] ? CW'(SS_LSLOW_CYC - 1) : CW'(SS_SLOW_CYC - 1);
      end
      stop = (sys_q == bkc_pkg::SYS_FAULT) | ~en_eff[c];
      short_ev[c] = short_s[c] & (st_q[c] == bkc_pkg::CH_RAMP || st_q[c] == bkc_pkg::CH_RUN);
      // Protection acts on every short during ramp or run; the mask only silences the interrupt line.
      case (st_q[c])
        bkc_pkg::CH_OFF: begin
          code_d[c] = tgt;
          if (!stop) begin
            st_d[c]  = bkc_pkg::CH_RAMP;
            cnt_d[c] = ramp;
          end
        end
        bkc_pkg::CH_RAMP: begin
          code_d[c] = tgt;
          if (stop) begin
            st_d[c] = bkc_pkg::CH_OFF;
          end else if (short_ev[c]) begin
            st_d[c]  = bkc_pkg::CH_WAIT;
            cnt_d[c] = CW'(RESTART_CYC - 1);
          end else if (cnt_q[c] == '0) begin
            st_d[c] = bkc_pkg::CH_RUN;
          end else begin
            cnt_d[c] = cnt_q[c] - CW'(1);
          end
        end
        bkc_pkg::CH_RUN: begin
          if (stop) begin
            st_d[c] = bkc_pkg::CH_OFF;
          end else if (short_ev[c]) begin
            st_d[c]  = bkc_pkg::CH_WAIT;
            cnt_d[c] = CW'(RESTART_CYC - 1);
          end else if (slew_tick && code_q[c] != tgt) begin
            code_d[c] = (code_q[c] < tgt) ? code_q[c] + 8'h01 : code_q[c] - 8'h01;
          end
        end
        bkc_pkg::CH_WAIT: begin
          if (stop) begin
            st_d[c] = bkc_pkg::CH_OFF;
          end else if (cnt_q[c] == '0) begin
            st_d[c]  = bkc_pkg::CH_RAMP;
            cnt_d[c] = ramp;
          end else begin
            cnt_d[c] = cnt_q[c] - CW'(1);
          end
        end
        default: st_d[c] = bkc_pkg::CH_OFF;
      endcase
      on_d[c]    = (st_d[c] == bkc_pkg::CH_RAMP) || (st_d[c] == bkc_pkg::CH_RUN);
      force_d[c] = (st_q[c] == bkc_pkg::CH_RUN) && (code_q[c] != tgt);
      pg_d[c]    = (st_q[c] == bkc_pkg::CH_RUN) && !uv_s[c];
      hold_d[c]  = (st_q[c] == bkc_pkg::CH_RUN) && duty_s[c];
      cut_d[c]   = on_d[c] && lim_s[c];
      tuv_d[c]   = decode_uv(code_d[c], low_ref[c]);
      // Flags: a new event wins over a clearing read in the same cycle.
      uvf_d[c] = (uvf_q[c] & ~clr[c]) | ((st_q[c] == bkc_pkg::CH_RUN) & uv_s[c]);
      ovf_d[c] = (ovf_q[c] & ~clr[c]) | ((st_q[c] == bkc_pkg::CH_RUN) & ov_s[c])
               | (force_q[c] & (pri_q[c] <= sec_q[c]));
      shf_d[c] = (shf_q[c] & ~clr[c]) | short_ev[c];
      vint_d[c] = vint_q[c];
      seen_d[c] = seen_q[c] | (clr[c] & vint_q[c]);
      if (seen_q[c] && (st_q[c] != bkc_pkg::CH_RUN || pg_q[c])) begin
        vint_d[c] = 1'b0;
        seen_d[c] = 1'b0;
      end
      if ((uvf_d[c] & ~uvf_q[c]) | (ovf_d[c] & ~ovf_q[c])) begin
        vint_d[c] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int c = 0; c < 3; c++) begin
        st_q[c]  <= bkc_pkg::CH_OFF;
        cnt_q[c] <= '0;
      end
      code_q    <= '0;
      slew_q    <= '0;
      {ovf_q, uvf_q, shf_q, vint_q, seen_q} <= '0;
      {pg_q, force_q, reg_enable, hs_hold, hs_cut} <= '0;
      target_uv <= '0;
    end else begin
      for (int c = 0; c < 3; c++) begin
        st_q[c]  <= st_d[c];
        cnt_q[c] <= cnt_d[c];
      end
      code_q    <= code_d;
      slew_q    <= slew_d;
      {ovf_q, uvf_q, shf_q, vint_q, seen_q} <= {ovf_d, uvf_d, shf_d, vint_d, seen_d};
      {pg_q, force_q, reg_enable, hs_hold, hs_cut} <= {pg_d, force_d, on_d, hold_d, cut_d};
      target_uv <= tuv_d;
    end
  end

  // Read port and interrupt line.
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       irq_n_q;
  logic       irq_n_d;
  logic [2:0] rd_bank;
  assign rd_bank = bank_hit(reg_addr);

  always_comb begin
    rdata_d = 8'h00;
    irq_n_d = 1'b1;
    if (reg_rd) begin
      if (reg_addr == bkc_pkg::ADDR_GLB) begin
        rdata_d = glb_q;
      end else if (reg_addr == bkc_pkg::ADDR_SYS) begin
        rdata_d = {6'h00, sys_q == bkc_pkg::SYS_FAULT, extra_light_load_mode};
      end
      for (int c = 0; c < 3; c++) begin
        if (rd_bank[c]) begin
          case (reg_addr[2:0])
            bkc_pkg::OFS_PRI:  rdata_d = pri_q[c];
            bkc_pkg::OFS_SEC:  rdata_d = sec_q[c];
            bkc_pkg::OFS_CTL: begin
              rdata_d = ctl_q[c];
              if (c == 0) begin
                rdata_d[bkc_pkg::CTL_REF] = REG1_LOW_REF;
              end
            end
            bkc_pkg::OFS_ILIM: rdata_d = {4'h0, ilim_q[c]};
            bkc_pkg::OFS_STAT: rdata_d = {ramp_busy[c], force_q[c], shf_q[c], lim_f[c],
                                          warn_f[c], uvf_q[c], ovf_q[c], pg_q[c]};
            default: rdata_d = 8'h00;
          endcase
        end
      end
    end
    // Masks silence only the line; flags and protection carry on regardless.
    for (int c = 0; c < 3; c++) begin
      if ((vint_q[c] && !ctl_q[c][bkc_pkg::CTL_VMASK]) ||
          ((warn_f[c] | lim_f[c] | shf_q[c]) && !ctl_q[c][bkc_pkg::CTL_CMASK])) begin
        irq_n_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
      irq_n_q <= 1'b1;
    end else begin
      rdata_q <= rdata_d;
      irq_n_q <= irq_n_d;
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_out
    assign ramp_busy[g]             = (st_q[g] == bkc_pkg::CH_RAMP);
    assign discharge_en[g]          = ~reg_enable[g];
    assign fixed_frequency_force[g] = force_q[g];
    assign peak_limit_setting[g]    = ilim_q[g];
    assign phase_delay_en[g]        = ctl_q[g][bkc_pkg::CTL_PDLY];
    assign phase_fall_edge[g]       = ctl_q[g][bkc_pkg::CTL_PFALL];
    assign fsw_half[g]              = ctl_q[g][bkc_pkg::CTL_FSW];
  end

  assign extra_light_load_mode = ~glb_q[bkc_pkg::GLB_LLD] & glb_q[bkc_pkg::GLB_LPS];
  assign voltage_fault_state   = (sys_q == bkc_pkg::SYS_FAULT);
  assign reg_rdata             = rdata_q;
  assign interrupt_out_n       = irq_n_q;
endmodule

// >>> bkc_properties.sv
`timescale 1ns/1ps
module bkc_checker (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic [2:0] lim_cmp,
  input wire logic [2:0] short_cmp,
  input wire logic [2:0] duty_full,
  input wire logic [2:0] reg_enable,
  input wire logic [2:0] discharge_en,
  input wire logic [2:0] ramp_busy,
  input wire logic [2:0] hs_hold,
  input wire logic [2:0] hs_cut,
  input wire logic       extra_light_load_mode,
  input wire logic       voltage_fault_state
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_discharge_when_off: assert property (discharge_en == ~reg_enable)
    else $error("discharge switch does not follow regulator off");
  a_light_load_mode: assert property (reg_wr && reg_addr == 8'h00 |=>
    extra_light_load_mode == (!$past(reg_wdata[0]) && $past(reg_wdata[1])))
    else $error("light load mode does not match written bits");
  a_off_write_stops: assert property (
    reg_wr && reg_addr == 8'h12 && !reg_wdata[0] |-> ##2 !reg_enable[0])
    else $error("regulator stays on after off write");
  a_hold_needs_full: assert property (!duty_full[2] [*6] |-> !hs_hold[2])
    else $error("high side held without full duty");
  a_cut_needs_limit: assert property (!lim_cmp[0] [*6] |-> !hs_cut[0])
    else $error("conduction cut without limit");
  a_short_fault: assert property (
    $rose(short_cmp[0]) && reg_enable[0] |-> ##[1:8] voltage_fault_state)
    else $error("short did not enter fault state");
  a_fault_all_off: assert property (voltage_fault_state [*2] |-> reg_enable == 3'h0)
    else $error("regulator on during fault state");
  // Eight cycles minimum keeps the shortest low reference ramp inside the window.
  a_ramp_length: assert property (
    $rose(ramp_busy[0]) |-> ramp_busy[0] [*8] ##[6:33] !ramp_busy[0])
    else $error("soft start length out of range");
endmodule

bind bkc_top bkc_checker u_chk (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .lim_cmp(lim_cmp), .short_cmp(short_cmp), .duty_full(duty_full),
  .reg_enable(reg_enable), .discharge_en(discharge_en), .ramp_busy(ramp_busy),
  .hs_hold(hs_hold), .hs_cut(hs_cut), .extra_light_load_mode(extra_light_load_mode),
  .voltage_fault_state(voltage_fault_state));

// >>> bkc_stage.sv
`timescale 1ns/1ps
module bkc_stage (
  input wire logic       core_clk,
  input wire logic [2:0] reg_enable,
  input wire logic [2:0] ramp_busy,
  output logic     [2:0] sw_tick,
  output logic     [2:0] uv_cmp
);
  logic [2:0] cnt_q = 3'h0;
  always @(posedge core_clk) cnt_q <= cnt_q + 3'h1;
  // A stopped regulator does not switch, so no cycle markers reach the counters.
  assign sw_tick = {3{cnt_q[2]}} & reg_enable;
  assign uv_cmp  = ~reg_enable | ramp_busy;
endmodule

// >>> buck_regulator_control_faults_test.sv
`timescale 1ns/1ps
module buck_regulator_control_faults_test;
  logic             core_clk, rst, reg_wr, reg_rd, dvs_pin, elm, vfs, irq_n;
  logic [7:0]       reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [2:0]       sw_tick, warn_cmp, lim_cmp, short_cmp, ov_cmp, uv_cmp, duty_full;
  logic [2:0]       reg_enable, discharge_en, ramp_busy, hs_hold, hs_cut, ffp, pde, pfe, fsh;
  logic [2:0][3:0]  pls;
  logic [2:0][21:0] target_uv;
  logic [15:0]      rst_tbl [6] = '{16'h0000, 16'h1080, 16'h1160, 16'h1201, 16'h1308, 16'h3000};
  int               err_count, check_count;
  bkc_top #(.SS_SLOW_CYC(40), .SS_FAST_CYC(20), .SS_LSLOW_CYC(30), .SS_LFAST_CYC(15),
    .RESTART_CYC(50), .SYS_RESTART_CYC(80), .SLEW_CYC(4)) dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dvs_pin(dvs_pin),
    .sw_tick(sw_tick), .warn_cmp(warn_cmp), .lim_cmp(lim_cmp), .short_cmp(short_cmp),
    .uv_cmp(uv_cmp), .ov_cmp(ov_cmp), .duty_full(duty_full), .reg_enable(reg_enable),
    .discharge_en(discharge_en), .ramp_busy(ramp_busy), .hs_hold(hs_hold), .hs_cut(hs_cut),
    .fixed_frequency_force(ffp), .target_uv(target_uv), .peak_limit_setting(pls),
    .phase_delay_en(pde), .phase_fall_edge(pfe), .fsw_half(fsh), .extra_light_load_mode(elm),
    .voltage_fault_state(vfs), .interrupt_out_n(irq_n));
  bkc_stage stage (.core_clk(core_clk), .reg_enable(reg_enable), .ramp_busy(ramp_busy),
    .sw_tick(sw_tick), .uv_cmp(uv_cmp));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic close_out;
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  function automatic logic [31:0] exp_uv(input bit low, input int code);
    return low ? 600000 + code * 9376 : 800000 + code * 12500;
  endfunction
  // Codes stay below 0x40 so each write starts a slew away from the reset setpoint.
  task automatic set_code(input int ch, input bit low);
    logic [7:0] code;
    code = 8'($urandom_range(0, 63));
    wr(8'h10 + 8'(ch * 8), code);
    wait_clk(8);
    chk(ffp[ch], 1'b1);
    wait_clk(1100);
    chk(ffp[ch], 1'b0);
    chk(target_uv[ch], exp_uv(low, code));
  endtask
  initial begin
    #400000;
    err_count++;
    close_out;
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    dvs_pin = 1'b0;
    {warn_cmp, lim_cmp, short_cmp, ov_cmp, duty_full} = 15'h0000;
    err_count = 0;
    check_count = 0;
    void'($urandom(34));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rst_tbl[i]) begin
      rd(rst_tbl[i][15:8], rd_val);
      chk(rd_val, rst_tbl[i][7:0]);
    end
    chk(pls, 12'h888);
    for (int v = 0; v < 4; v++) begin
      wr(8'h00, 8'(v));
      wait_clk(1);
      chk(elm, v == 2);
      rd(8'h01, rd_val);
      chk(rd_val[0], v == 2);
    end
    wait_clk(60);
    set_code(0, 1'b0);
    set_code(1, 1'b1);
    set_code(2, 1'b0);
    dvs_pin <= 1'b1;
    wait_clk(1100);
    chk(target_uv[2], exp_uv(1'b0, 8'h60));
    rd(8'h24, rd_val);
    chk(rd_val[1], 1'b1);
    dvs_pin <= 1'b0;
    wr(8'h12, 8'h21);
    wr(8'h1A, 8'h21);
    wr(8'h22, 8'h3D);
    duty_full <= 3'h4;
    wait_clk(6);
    chk(hs_hold, 3'h4);
    chk(irq_n, 1'b1);
    chk({pde, pfe, fsh}, 9'h124);
    rd(8'h14, rd_val);
    chk(rd_val[1], 1'b1);
    duty_full <= 3'h0;
    lim_cmp <= 3'h1;
    wait_clk(6);
    chk(hs_cut[0], 1'b1);
    lim_cmp <= 3'h0;
    warn_cmp <= 3'h2;
    wait_clk(200);
    warn_cmp <= 3'h0;
    wait_clk(10);
    chk(irq_n, 1'b0);
    rd(8'h1C, rd_val);
    chk(rd_val[3], 1'b1);
    rd(8'h1C, rd_val);
    chk(rd_val[3], 1'b0);
    wr(8'h12, 8'h00);
    wait_clk(3);
    chk(reg_enable[0], 1'b0);
    chk(discharge_en[0], 1'b1);
    wr(8'h12, 8'h21);
    wait_clk(60);
    short_cmp <= 3'h1;
    wait_clk(8);
    chk(vfs, 1'b1);
    chk(irq_n, 1'b0);
    chk(reg_enable, 3'h0);
    short_cmp <= 3'h0;
    wait_clk(200);
    chk(vfs, 1'b0);
    chk(reg_enable[0], 1'b1);
    wr(8'h12, 8'h01);
    rd(8'h14, rd_val);
    chk(rd_val[5], 1'b1);
    chk(rd_val[0], 1'b1);
    wait_clk(3);
    chk(irq_n, 1'b1);
    close_out;
  end
endmodule
